// File: dv/tb.sv
// Testbench: both loopback ends, plus a mobile on a mirrored link with one corrupted bit
`timescale 1ns/1ps
`define CHK(a, b) begin \
  n_tests++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); \
  end \
end
module tb
  import tclb_pkg::*;
;
  localparam int T_LIMIT = 50000;
  localparam logic [23:0] T_SSI = 24'h3c_5a96;
  localparam logic [59:0] T_TEI = 60'h123_4567_89ab_cdef;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] ssi = 24'h00_0000;
  logic [59:0] tei = 60'h000_0000_0000_0000;
  logic [3:0] power_class = 4'h0;
  logic [1:0] rx_class = 2'h0;
  logic seq_nr = 1'b0;
  logic seq_ns = 1'b0;
  logic usr1;
  logic usr_b1;
  logic loop1;
  logic bad1;
  logic bad2;
  logic [8:0] dpos_q = 9'h000;
  logic d1 [BLK_BITS];
  logic d2 [BLK_BITS];
  logic [CONF_BITS-1:0] cf_vec;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int di = 0;
  int u1 = 0;
  int u2 = 0;
  int ul_tot = 0;
  int usr_n = 0;
  int bf1_n = 0;
  int bf2_n = 0;
  int cf_n = 0;
  always #5 pclk = ~pclk;
  // Scrambler bit k of a burst: 9-stage register, taps 9 and 5
  function automatic logic scr_bit(input int k);
    logic [8:0] s;
    s = SCR_SEED;
    for (int i = 0; i < k; i++) begin
      s = {s[7:0], s[8] ^ s[4]};
    end
    return s[8];
  endfunction
  tclb_link_if lnk1 (.pclk(pclk), .presetn(presetn));
  tclb_link_if lnk2 (.pclk(pclk), .presetn(presetn));
  tclb_test_sys tclb_test_sys_inst (.lnk(lnk1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  tclb_mobile tclb_mobile_inst (.lnk(lnk1), .ssi(ssi), .tei(tei), .power_class(power_class),
    .rx_class(rx_class), .seq_nr(seq_nr), .seq_ns(seq_ns), .usr_valid(usr1), .usr_bit(usr_b1),
    .bad_frame(bad1), .looping(loop1));
  tclb_mobile tclb_mobile_fault_inst (.lnk(lnk2), .ssi(ssi), .tei(tei),
    .power_class(power_class), .rx_class(rx_class), .seq_nr(seq_nr), .seq_ns(seq_ns),
    .usr_valid(), .usr_bit(), .bad_frame(bad2), .looping());
  tclb_link_checker tclb_link_checker_inst (.pclk(pclk), .presetn(presetn),
    .dl_valid(lnk1.dl_valid), .dl_sob(lnk1.dl_sob), .ul_valid(lnk1.ul_valid),
    .ul_sob(lnk1.ul_sob), .ul_bit(lnk1.ul_bit), .cf_req(lnk1.cf_req),
    .cf_valid(lnk1.cf_valid));
  // ********************
  // Mirrored link: class-2 bit 220 inverted
  // ********************
  wire flip = lnk1.dl_valid && !lnk1.dl_sob && (dpos_q == 9'h0dc);
  assign lnk2.dl_valid = lnk1.dl_valid;
  assign lnk2.dl_sob = lnk1.dl_sob;
  assign lnk2.dl_bit = lnk1.dl_bit ^ flip;
  assign lnk2.ch_speech = lnk1.ch_speech;
  assign lnk2.lb_active = lnk1.lb_active;
  assign lnk2.lb_type = lnk1.lb_type;
  assign lnk2.cf_req = 1'b0;
  always @(posedge pclk) begin
    if (lnk1.dl_valid) dpos_q <= lnk1.dl_sob ? 9'h001 : dpos_q + 9'h001;
  end
  // Wire monitor: returned bits against the bits sent, counts of pulses
  always @(posedge pclk) begin
    if (lnk1.dl_valid) begin
      di = lnk1.dl_sob ? 0 : di + 1;
      d1[di] = lnk1.dl_bit;
      d2[di] = lnk2.dl_bit;
    end
    if (lnk1.ul_valid) begin
      u1 = lnk1.ul_sob ? 0 : u1 + 1;
      ul_tot++;
      `CHK(lnk1.ul_bit, d1[u1])
    end
    if (lnk2.ul_valid) begin
      u2 = lnk2.ul_sob ? 0 : u2 + 1;
      if (!lnk2.ch_speech || u2 > 281) `CHK(lnk2.ul_bit, d2[u2])
      else if (lnk2.lb_type == LB_BFI && u2 < T1_BITS) `CHK(lnk2.ul_bit, ~scr_bit(u2))
    end
    if (usr1 === 1'b1) begin
      usr_n++;
      `CHK(usr_b1, d1[di] ^ scr_bit(di))
    end
    if (bad1 === 1'b1) bf1_n++;
    if (bad2 === 1'b1) bf2_n++;
    if (lnk1.cf_valid) begin
      cf_vec = {cf_vec[CONF_BITS-2:0], lnk1.cf_bit};
      cf_n++;
    end
  end
  // ********************
  // Tasks
  // ********************
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == T_LIMIT) begin
      err_count++;
      test_done();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, wd, x, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0000_0000, x, e);
    `CHK(x, exp)
    `CHK(e, 1'b0)
  endtask
  // Clear counters, loop two bursts, stop in the fill gap
  task automatic run_bursts(input logic [31:0] ctrl);
    int t;
    t = ul_tot + 2 * BLK_BITS;
    wr(A_CTRL, ctrl | 32'h0000_0010);
    @(posedge pclk);
    `CHK(loop1, 1'b1)
    while (ul_tot < t) @(posedge pclk);
    wr(A_CTRL, W_RST);
    @(posedge pclk);
    `CHK(loop1, 1'b0)
  endtask
  task automatic t_regs();
    logic [31:0] x;
    logic e;
    for (int a = 0; a < 6; a++) begin
      rdchk(8'(4 * a), W_RST);
    end
    apb(1'b0, 8'h18, 32'h0000_0000, x, e);
    `CHK(e, 1'b1)
    `CHK(x, W_RST)
    wr(8'h18, 32'h0000_0007);
    rdchk(A_CTRL, W_RST);
    wr(A_CTRL, 32'h0000_0004);
    @(posedge pclk);
    `CHK(lnk1.lb_type, LB_BFI)
    rdchk(A_CTRL, 32'h0000_0004);
    wr(A_CTRL, W_RST);
    @(posedge pclk);
    `CHK(lnk1.lb_type, LB_PLAIN)
  endtask
  task automatic t_conf();
    logic [CONF_BITS-1:0] x;
    int n;
    ssi <= T_SSI;
    tei <= T_TEI;
    power_class <= 4'h3;
    rx_class <= 2'h1;
    seq_nr <= 1'b1;
    x = {2'h0, 1'h0, 1'h0, 2'h0, T_SSI, 1'h0, 6'h0f, 4'h0, 1'h1, 1'h0, 3'h7, 5'h11, 2'h0,
         T_TEI, 4'h3, 2'h1, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0, T_SSI, 1'h1, 6'h00, 1'h1, 110'h0};
    n = cf_n + CONF_BITS;
    wr(A_CTRL, 32'h0000_0008);
    while (cf_n < n) @(posedge pclk);
    repeat (12) @(posedge pclk);
    `CHK(cf_n, n)
    `CHK(cf_vec, x)
    rdchk(A_CONF, x[31:0]);
  endtask
  task automatic t_data();
    int un;
    int b2;
    un = usr_n;
    b2 = bf2_n;
    run_bursts(32'h0000_0001);
    rdchk(A_ERRS, W_RST);
    rdchk(A_BITS, 32'(2 * BLK_BITS));
    rdchk(A_STAT, W_RST);
    `CHK(usr_n - un, 2 * BLK_BITS)
    `CHK(bf2_n - b2, 0)
  endtask
  task automatic t_speech();
    int un;
    int b1;
    int b2;
    un = usr_n;
    b1 = bf1_n;
    b2 = bf2_n;
    run_bursts(32'h0000_0003);
    rdchk(A_ERRS, W_RST);
    rdchk(A_BITS, 32'(4 * FRM_BITS));
    `CHK(usr_n - un, 0)
    `CHK(bf1_n - b1, 0)
    `CHK(bf2_n - b2, 2)
  endtask
  task automatic t_speech_bfi();
    int b2;
    b2 = bf2_n;
    run_bursts(32'h0000_0007);
    rdchk(A_BAD, W_RST);
    rdchk(A_BITS, 32'(4 * FRM_BITS));
    `CHK(bf2_n - b2, 2)
  endtask
  task automatic t_data_bfi();
    int b2;
    b2 = bf2_n;
    run_bursts(32'h0000_0005);
    rdchk(A_ERRS, W_RST);
    rdchk(A_BITS, 32'(2 * BLK_BITS));
    `CHK(bf2_n - b2, 0)
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_conf();
    t_data();
    t_speech();
    t_speech_bfi();
    t_data_bfi();
    test_done();
  end
endmodule // tb

// File: dv/tclb_link_checker.sv
// Timing checks on the link between the test system and the mobile
`timescale 1ns/1ps
module tclb_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dl_valid,
  input wire logic dl_sob,
  input wire logic ul_valid,
  input wire logic ul_sob,
  input wire logic ul_bit,
  input wire logic cf_req,
  input wire logic cf_valid
);
  // ********************
  // Bit counters
  // ********************
  logic [8:0] dn_q;
  logic [8:0] un_q;
  logic [8:0] cn_q;
  wire dl_last = dl_valid && !dl_sob && (dn_q == 9'h1af);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dn_q <= 9'h000;
      un_q <= 9'h000;
      cn_q <= 9'h000;
    end else begin
      if (dl_valid) dn_q <= dl_sob ? 9'h001 : dn_q + 9'h001;
      if (ul_valid) un_q <= ul_sob ? 9'h001 : un_q + 9'h001;
      if (cf_req) cn_q <= 9'h000;
      else if (cf_valid) cn_q <= cn_q + 9'h001;
    end
  end
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_dl_sob_valid: assert property (dl_sob |-> dl_valid)
    else $error("downlink burst start without a bit");
  chk_ul_sob_valid: assert property (ul_sob |-> ul_valid)
    else $error("uplink burst start without a bit");
  chk_dl_bit_gap: assert property (dl_valid |=> !dl_valid [*3])
    else $error("downlink bits closer than four cycles");
  chk_ul_bit_gap: assert property (ul_valid |=> !ul_valid [*3])
    else $error("uplink bits closer than four cycles");
  chk_loop_delay: assert property (dl_last |=> !ul_valid [*5] ##1 (ul_valid && ul_sob))
    else $error("uplink burst not six cycles after last downlink bit");
  chk_ul_burst_len: assert property (ul_sob |-> (un_q == 9'h000 || un_q == 9'h1b0))
    else $error("uplink burst cut short");
  chk_ul_no_extra: assert property (ul_valid && !ul_sob |-> un_q < 9'h1b0)
    else $error("uplink burst longer than a block");
  chk_ul_bit_hold: assert property (!ul_valid |=> (ul_valid || $stable(ul_bit)))
    else $error("uplink bit moved between strobes");
  chk_cf_bit_gap: assert property (cf_valid |=> !cf_valid [*3])
    else $error("confirmation bits closer than four cycles");
  chk_cf_block_len: assert property (cf_valid |-> cn_q < 9'h10c)
    else $error("confirmation block longer than its size");
  chk_cf_req_start: assert property (cf_req |-> ##[1:8] cf_valid)
    else $error("confirmation block did not start");
endmodule // tclb_link_checker

// File: verilog/tclb_lfsr.sv
// Nine-stage sequence generator, feedback from stages 9 and 5
`timescale 1ns/1ps
module tclb_lfsr
  import tclb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic step,
  input wire logic [8:0] seed,
  output logic bit_o
);
  logic [8:0] st_q;
  logic [8:0] st_d;

  assign st_d = {st_q[7:0], st_q[8] ^ st_q[4]};
  assign bit_o = st_q[8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= PRBS_SEED;
    end else if (load) begin
      st_q <= seed;
    end else if (step) begin
      st_q <= st_d;
    end
  end
endmodule // tclb_lfsr

// File: verilog/tclb_link_if.sv
// Link between the test system and the mobile under loopback test
`timescale 1ns/1ps
interface tclb_link_if (
  input logic pclk,
  input logic presetn
);
  logic dl_valid;
  logic dl_sob;
  logic dl_bit;
  logic ch_speech;
  logic lb_active;
  logic [4:0] lb_type;
  logic cf_req;
  logic ul_valid;
  logic ul_sob;
  logic ul_bit;
  logic cf_valid;
  logic cf_bit;

  modport test_sys (
    input pclk, presetn, ul_valid, ul_sob, ul_bit, cf_valid, cf_bit,
    output dl_valid, dl_sob, dl_bit, ch_speech, lb_active, lb_type, cf_req
  );
  modport mobile (
    input pclk, presetn, dl_valid, dl_sob, dl_bit, ch_speech, lb_active, lb_type, cf_req,
    output ul_valid, ul_sob, ul_bit, cf_valid, cf_bit
  );
endinterface

// File: verilog/tclb_mobile.sv
// Mobile end: traffic channel loopback and test-mode confirmation
`timescale 1ns/1ps
// Behaviour
// - Tester sends 432-bit PRBS chunks, scrambled.
// - Data channel: descramble, rescramble, return 432 bits.
// - Scrambled data bits may be returned directly.
// - Loop delay constant from burst to burst.
// - Data may also go to user output.
// - Tester descrambles returned data, totals errors.
// - Tester takes two 137-bit speech frames.
// - Tester codes speech into 432-bit burst.
// - Mobile decodes speech burst to type-2 bits.
// - Class-2 parity mismatch marks bad frame.
// - Mobile re-encodes speech and returns burst.
// - Type-2 bits may loop with recomputed parity.
// - Bad frame with marking: samples all ones.
// - Looped speech not routed to audio.
// - Tester compares returned speech frames, totals errors.
// - Tester excludes all-ones frames when marking.
// - Confirmation starts with fixed MAC header.
// - Link type, sequence bits, test discriminator follow.
// - Confirm PDU carries identity and classes.
// - Null PDU and fill complete 268 bits.
// - Tester selects loop via 5-bit type.
// - Bad-frame marking ignored on data channel.
module tclb_mobile
  import tclb_pkg::*;
(
  tclb_link_if.mobile lnk,
  input wire logic [23:0] ssi,
  input wire logic [59:0] tei,
  input wire logic [3:0] power_class,
  input wire logic [1:0] rx_class,
  input wire logic seq_nr,
  input wire logic seq_ns,
  output logic usr_valid,
  output logic usr_bit,
  output logic bad_frame,
  output logic looping
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_FIX = 3'b010,
    ST_TX = 3'b011,
    ST_CONF = 3'b100
  } tclb_mst_t;

  tclb_mst_t st_q;
  logic [8:0] cnt_q;
  logic [2:0] div_q;
  logic [BLK_BITS-1:0] buf_q;
  logic speech_q;
  logic bfi_q;
  logic cf_pend_q;
  logic ul_valid_q;
  logic ul_sob_q;
  logic ul_bit_q;
  logic cf_valid_q;
  logic cf_bit_q;
  logic usr_valid_q;
  logic usr_bit_q;
  logic bad_q;

  // ****************************************
  // Decode
  // ****************************************
  wire scr;
  wire tick = (div_q == BIT_DIV);
  wire last = (cnt_q == LAST_BIT);
  wire loop_on = lnk.lb_active && (lnk.lb_type == LB_PLAIN || lnk.lb_type == LB_BFI);
  wire bfi_req = (lnk.lb_type == LB_BFI) && lnk.ch_speech;
  wire rx_start = (st_q == ST_IDLE) && loop_on && lnk.dl_valid && lnk.dl_sob;
  wire rx_take = rx_start || ((st_q == ST_RX) && lnk.dl_valid);
  wire rx_speech = (st_q == ST_IDLE) ? lnk.ch_speech : speech_q;
  // Speech is descrambled before decoding; data stays scrambled
  wire rx_bit = lnk.dl_bit ^ (rx_speech & scr);
  wire tx_take = (st_q == ST_TX) && tick;
  wire cf_start = (st_q == ST_IDLE) && cf_pend_q && !rx_start;
  // Held at the seed while idle; the first received bit already steps it
  wire scr_load = ((st_q == ST_IDLE) && !rx_start) || (st_q == ST_FIX);
  wire [CONF_BITS-1:0] conf_w = tclb_conf(ssi, tei, power_class, rx_class, seq_nr, seq_ns);
  wire [8:0] conf_idx = 9'(CONF_BITS - 1) - cnt_q;
  wire bad_w = tclb_parity(buf_q) != buf_q[PAR_POS +: PAR_BITS];
  wire kill_w = speech_q && bfi_q && bad_w;
  wire [BLK_BITS-1:0] fix_w = kill_w ? {buf_q[BLK_BITS-1:T1_BITS], {T1_BITS{1'b1}}} : buf_q;
  wire [BLK_BITS-1:0] code_w = {fix_w[BLK_BITS-1:PAR_POS+PAR_BITS], tclb_parity(fix_w),
                                fix_w[T1_BITS-1:0]};

  tclb_lfsr u_scr (
    .pclk(lnk.pclk),
    .presetn(lnk.presetn),
    .load(scr_load),
    .step(rx_take || tx_take),
    .seed(SCR_SEED),
    .bit_o(scr)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= CNT_RST;
      speech_q <= 1'b0;
      bfi_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          cnt_q <= CNT_RST;
          if (rx_start) begin
            st_q <= ST_RX;
            cnt_q <= 9'h001;
            speech_q <= lnk.ch_speech;
            bfi_q <= bfi_req;
          end else if (cf_start) begin
            st_q <= ST_CONF;
          end
        end
        ST_RX: begin
          if (lnk.dl_valid) begin
            cnt_q <= cnt_q + 9'h001;
            if (last) begin
              st_q <= ST_FIX;
            end
          end
        end
        ST_FIX: begin
          st_q <= ST_TX;
          cnt_q <= CNT_RST;
        end
        ST_TX: begin
          if (tick) begin
            cnt_q <= cnt_q + 9'h001;
            if (last) begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_CONF: begin
          if (tick) begin
            cnt_q <= cnt_q + 9'h001;
            if (conf_idx == 9'h000) begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Divider restarts at each return so the loop delay never drifts
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      div_q <= 3'h0;
    end else if (st_q == ST_FIX || cf_start || tick) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // ****************************************
  // Burst buffer
  // ****************************************
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      buf_q <= '0;
    end else if (rx_take) begin
      buf_q[cnt_q] <= rx_bit;
    end else if (st_q == ST_FIX && speech_q) begin
      buf_q <= code_w;
    end
  end

  // ****************************************
  // Uplink and user outputs
  // ****************************************
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      ul_valid_q <= 1'b0;
      ul_sob_q <= 1'b0;
      ul_bit_q <= 1'b0;
      cf_valid_q <= 1'b0;
      cf_bit_q <= 1'b0;
      usr_valid_q <= 1'b0;
      usr_bit_q <= 1'b0;
      bad_q <= 1'b0;
      cf_pend_q <= 1'b0;
    end else begin
      ul_valid_q <= tx_take;
      ul_sob_q <= tx_take && (cnt_q == CNT_RST);
      if (tx_take) begin
        ul_bit_q <= buf_q[cnt_q] ^ (speech_q & scr);
      end
      cf_valid_q <= (st_q == ST_CONF) && tick;
      if ((st_q == ST_CONF) && tick) begin
        cf_bit_q <= conf_w[conf_idx];
      end
      usr_valid_q <= rx_take && !rx_speech;
      if (rx_take) begin
        usr_bit_q <= lnk.dl_bit ^ scr;
      end
      bad_q <= (st_q == ST_FIX) && speech_q && bad_w;
      cf_pend_q <= lnk.cf_req || (cf_pend_q && !cf_start);
    end
  end

  assign lnk.ul_valid = ul_valid_q;
  assign lnk.ul_sob = ul_sob_q;
  assign lnk.ul_bit = ul_bit_q;
  assign lnk.cf_valid = cf_valid_q;
  assign lnk.cf_bit = cf_bit_q;
  assign usr_valid = usr_valid_q;
  assign usr_bit = usr_bit_q;
  assign bad_frame = bad_q;
  assign looping = loop_on;
endmodule // tclb_mobile

// File: verilog/tclb_pkg.sv
// Constants, field layouts and helpers shared by both loopback ends
package tclb_pkg;
  // ****************************************
  // Burst and frame layout
  // ****************************************
  localparam int BLK_BITS = 432;
  localparam int FRM_BITS = 137;
  localparam int T1_BITS = 2 * FRM_BITS;
  localparam int PAR_POS = 274;
  localparam int PAR_BITS = 8;
  localparam int C2_POS = 214;
  localparam int C2_BITS = 60;
  localparam int CONF_BITS = 268;
  localparam logic [8:0] LAST_BIT = 9'h1af;
  localparam logic [8:0] CNT_RST = 9'h000;
  // Bit strobe: one bit every BIT_DIV+1 cycles
  localparam logic [2:0] BIT_DIV = 3'h3;
  localparam logic [8:0] PRBS_SEED = 9'h1ff;
  localparam logic [8:0] SCR_SEED = 9'h0a5;
  // Loopback type codes
  localparam logic [4:0] LB_PLAIN = 5'h01;
  localparam logic [4:0] LB_BFI = 5'h02;
  // ****************************************
  // Test system register map
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ERRS = 8'h04;
  localparam logic [7:0] A_BITS = 8'h08;
  localparam logic [7:0] A_BAD = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_CONF = 8'h14;
  localparam int C_RUN = 0;
  localparam int C_SPEECH = 1;
  localparam int C_BFI = 2;
  localparam int C_CONF = 3;
  localparam int C_CLR = 4;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] W_RST = 32'h0000_0000;

  // Parity over the class-2 bits, bit i folded into parity bit i mod 8
  function automatic logic [PAR_BITS-1:0] tclb_parity(input logic [BLK_BITS-1:0] v);
    logic [PAR_BITS-1:0] p;
    p = '0;
    for (int i = 0; i < C2_BITS; i++) begin
      p[i % PAR_BITS] = p[i % PAR_BITS] ^ v[C2_POS + i];
    end
    return p;
  endfunction

  // Test-mode confirmation MAC block, first bit sent is the MSB
  function automatic logic [CONF_BITS-1:0] tclb_conf(input logic [23:0] ssi,
      input logic [59:0] tei, input logic [3:0] pwr, input logic [1:0] rxc,
      input logic nr, input logic ns);
    return {2'h0, 1'h0, 1'h0, 2'h0, ssi, 1'h0, 6'h0f,
            4'h0, nr, ns, 3'h7,
            5'h11, 2'h0, tei, pwr, rxc, 1'h0,
            2'h0, 1'h1, 1'h0, 2'h0, ssi, 1'h1, 6'h00,
            1'h1, 110'h0};
  endfunction
endpackage

// File: verilog/tclb_test_sys.sv
// Test system end: burst generator, error counter and APB registers
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module tclb_test_sys
  import tclb_pkg::*;
(
  tclb_link_if.test_sys lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_FILL = 2'b01,
    H_SEND = 2'b10,
    H_RECV = 2'b11
  } tclb_hst_t;

  tclb_hst_t st_q;
  logic [8:0] cnt_q;
  logic [2:0] div_q;
  logic [BLK_BITS-1:0] buf_q;
  logic [2:0] ctrl_q;
  logic cf_req_q;
  logic [31:0] errs_q;
  logic [31:0] bits_q;
  logic [31:0] bad_q;
  logic [31:0] conf_q;
  logic [31:0] prdata_q;
  logic [8:0] eb_q;
  logic ones_q;
  logic dl_valid_q;
  logic dl_sob_q;
  logic dl_bit_q;

  // ****************************************
  // Decode
  // ****************************************
  wire prbs;
  wire scr;
  wire speech = ctrl_q[C_SPEECH];
  wire run = ctrl_q[C_RUN];
  wire [8:0] lim = speech ? 9'(T1_BITS) : 9'(BLK_BITS);
  wire tick = (div_q == BIT_DIV);
  wire last = (cnt_q == LAST_BIT);
  wire in_lim = cnt_q < lim;
  wire fill_on = st_q == H_FILL;
  wire send_on = (st_q == H_SEND) && tick;
  wire rx_on = (st_q == H_RECV) && lnk.ul_valid && (lnk.ul_sob || cnt_q != CNT_RST);
  wire rx_b = lnk.ul_bit ^ scr;
  wire [BLK_BITS-1:0] snd_w = speech ? {buf_q[BLK_BITS-1:PAR_POS+PAR_BITS], tclb_parity(buf_q),
                                        buf_q[T1_BITS-1:0]} : buf_q;
  wire e_now = in_lim && (rx_b != snd_w[cnt_q]);
  wire [8:0] eb_sum = eb_q + {8'h00, e_now};
  wire bad_burst = speech && ctrl_q[C_BFI] && ones_q;
  wire wr = psel && penable && pwrite;
  wire wr_ctrl = wr && (paddr == A_CTRL);
  wire mapped = paddr == A_CTRL || paddr == A_ERRS || paddr == A_BITS || paddr == A_BAD
             || paddr == A_STAT || paddr == A_CONF;
  wire [31:0] rd_w = (paddr == A_CTRL) ? {29'h0, ctrl_q} :
                     (paddr == A_ERRS) ? errs_q :
                     (paddr == A_BITS) ? bits_q :
                     (paddr == A_BAD) ? bad_q :
                     (paddr == A_STAT) ? {30'h0, st_q} :
                     (paddr == A_CONF) ? conf_q : W_RST;

  tclb_lfsr u_prbs (
    .pclk(lnk.pclk),
    .presetn(lnk.presetn),
    .load(1'b0),
    .step(fill_on && in_lim),
    .seed(PRBS_SEED),
    .bit_o(prbs)
  );

  tclb_lfsr u_scr (
    .pclk(lnk.pclk),
    .presetn(lnk.presetn),
    .load(fill_on || (send_on && last)),
    .step(send_on || rx_on),
    .seed(SCR_SEED),
    .bit_o(scr)
  );

  // ****************************************
  // Burst sequencer
  // ****************************************
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      st_q <= H_IDLE;
      cnt_q <= CNT_RST;
      div_q <= 3'h0;
      buf_q <= '0;
      eb_q <= 9'h000;
      ones_q <= 1'b1;
    end else begin
      div_q <= (tick || fill_on) ? 3'h0 : div_q + 3'h1;
      unique case (st_q)
        H_IDLE: begin
          cnt_q <= CNT_RST;
          if (run) begin
            st_q <= H_FILL;
          end
        end
        H_FILL: begin
          buf_q[cnt_q] <= in_lim & prbs;
          cnt_q <= last ? CNT_RST : cnt_q + 9'h001;
          // A stop in the fill gap ends the run before another burst goes out
          if (!run) begin
            st_q <= H_IDLE;
          end else if (last) begin
            st_q <= H_SEND;
          end
        end
        H_SEND: begin
          if (tick) begin
            cnt_q <= last ? CNT_RST : cnt_q + 9'h001;
            eb_q <= 9'h000;
            ones_q <= 1'b1;
            if (last) begin
              st_q <= H_RECV;
            end
          end
        end
        H_RECV: begin
          if (rx_on) begin
            cnt_q <= last ? CNT_RST : cnt_q + 9'h001;
            eb_q <= eb_sum;
            ones_q <= ones_q & (rx_b | ~in_lim);
            if (last) begin
              st_q <= run ? H_FILL : H_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Counters, control and APB
  // ****************************************
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      errs_q <= W_RST;
      bits_q <= W_RST;
      bad_q <= W_RST;
      conf_q <= W_RST;
      ctrl_q <= CTRL_RST;
      cf_req_q <= 1'b0;
      prdata_q <= W_RST;
    end else begin
      if (wr_ctrl && pwdata[C_CLR]) begin
        errs_q <= W_RST;
        bits_q <= W_RST;
        bad_q <= W_RST;
      end else if (rx_on && last) begin
        if (bad_burst) begin
          bad_q <= bad_q + 32'h0000_0001;
        end else begin
          errs_q <= errs_q + {23'h0, eb_sum};
          bits_q <= bits_q + {23'h0, lim};
        end
      end
      if (wr_ctrl) begin
        ctrl_q <= pwdata[2:0];
      end
      cf_req_q <= wr_ctrl && pwdata[C_CONF];
      if (lnk.cf_valid) begin
        conf_q <= {conf_q[30:0], lnk.cf_bit};
      end
      if (psel && !penable) begin
        prdata_q <= rd_w;
      end
    end
  end

  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      dl_valid_q <= 1'b0;
      dl_sob_q <= 1'b0;
      dl_bit_q <= 1'b0;
    end else begin
      dl_valid_q <= send_on;
      dl_sob_q <= send_on && (cnt_q == CNT_RST);
      if (send_on) begin
        dl_bit_q <= snd_w[cnt_q] ^ scr;
      end
    end
  end

  assign lnk.dl_valid = dl_valid_q;
  assign lnk.dl_sob = dl_sob_q;
  assign lnk.dl_bit = dl_bit_q;
  assign lnk.ch_speech = speech;
  assign lnk.lb_active = run;
  assign lnk.lb_type = ctrl_q[C_BFI] ? LB_BFI : LB_PLAIN;
  assign lnk.cf_req = cf_req_q;
  assign prdata = prdata_q;
  assign pready = penable;
  assign pslverr = psel && penable && !mapped;
endmodule // tclb_test_sys
